// *** clock_watchdog.sv ***
// watchdog that fires when the serial clock stays high too long
`timescale 1ns/1ps
`default_nettype none
module clock_watchdog #(
  parameter int LIMIT = framer_pkg::WATCH_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck_level,
  input wire logic sck_rise,
  output logic fire
);

  logic [15:0] high_count;
  logic armed;

  // timer runs only from a rising edge; a low clock never reaches the limit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      high_count <= 16'h0000;
      armed <= 1'b0;
      fire <= 1'b0;
    end
    else
    begin
      fire <= 1'b0;
      if (sck_rise)
      begin
        high_count <= 16'h0001; // RULE17
        armed <= 1'b1;
      end
      else if (!sck_level)
      begin
        high_count <= 16'h0000; // RULE18
        armed <= 1'b0;
      end
      else if (armed)
      begin
        if (high_count >= 16'(LIMIT))
        begin
          fire <= 1'b1; // RULE17
          armed <= 1'b0; // one reset per long high phase
        end
        else
          high_count <= high_count + 16'h0001;
      end
    end
  end

endmodule : clock_watchdog
`default_nettype wire

// *** frame_crc.sv ***
// serial crc-16 over frame bits, msb first, with a shift-out mode
`timescale 1ns/1ps
`default_nettype none
module frame_crc #(
  parameter logic [15:0] POLY = framer_pkg::CRC_POLY,
  parameter logic [15:0] SEED = framer_pkg::CRC_SEED
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic feed,
  input wire logic bit_in,
  input wire logic shift,
  output logic [15:0] crc
);

  logic [15:0] base;
  logic fb;

  // clear restarts from the seed and folds in the first bit the same cycle
  always_comb
  begin
    base = clear ? SEED : crc;
    fb = base[15] ^ bit_in;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crc <= 16'h0000;
    else if (feed)
      crc <= {base[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
    else if (shift)
      crc <= {crc[14:0], 1'b0}; // emptied onto the pin after the data
  end

endmodule : frame_crc
`default_nettype wire

// *** framer_pkg.sv ***
// shared constants and types for the two-wire framed converter output
package framer_pkg;

  // clock and watchdog timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int WATCH_MIN_NS = 3600;
  localparam int WATCH_CYCLES = (WATCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // frame layout
  localparam logic [7:0] SYNC_PATTERN = 8'hA5;
  localparam int SHORT_DATA_BITS = 48;
  localparam int LONG_DATA_BITS = 64;
  localparam int CRC_BITS = 16;
  localparam int FRAMES_PER_RESULT = 4;
  localparam int SAMPLE_BITS = 24;
  localparam int SHORT_SAMPLE_BITS = 16;

  // oversampling ratios and channel 0 gains by strap code
  localparam logic [11:0] RATIO_00 = 12'h040;
  localparam logic [11:0] RATIO_01 = 12'h080;
  localparam logic [11:0] RATIO_10 = 12'h100;
  localparam logic [11:0] RATIO_11 = 12'h200;
  localparam logic [5:0] GAIN_00 = 6'h01;
  localparam logic [5:0] GAIN_01 = 6'h08;
  localparam logic [5:0] GAIN_10 = 6'h10;
  localparam logic [5:0] GAIN_11 = 6'h20;

  // crc defaults (polynomial is a plain default, seed zero)
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_SEED = 16'h0000;

  // conversions discarded while the decimation filter settles
  localparam int SETTLE_RESULTS = 3;

  // straps as latched from the five configuration pins
  typedef struct packed {
    logic ratio_strap_high;
    logic ratio_strap_low;
    logic boost;
    logic gain_strap_high;
    logic gain_strap_low;
  } strap_t;

  // conversion schedule states
  typedef enum logic [1:0] {
    SCHED_OFF = 2'b00,
    SCHED_START = 2'b01,
    SCHED_CONVERT = 2'b10
  } sched_t;

endpackage : framer_pkg

// *** serial_controller.sv ***
// controller model: steady serial clock, stalls, bit receiver
`timescale 1ns/1ps
`default_nettype none
module serial_controller #(
  parameter int HALF = 7
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall_high,
  input wire logic stall_low,
  input wire logic serial_out,
  output logic serial_clock,
  output logic rx_strobe,
  output logic rx_bit
);
  logic [3:0] phase;
  // 112 ns period keeps under the top rate and far above the watchdog floor
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase <= 4'h0;
      serial_clock <= 1'b0;
      rx_strobe <= 1'b0;
      rx_bit <= 1'b0;
    end
    else
    begin
      rx_strobe <= 1'b0;
      phase <= (phase == 4'(HALF - 1)) ? 4'h0 : phase + 4'h1;
      if (phase == 4'(HALF - 1) && !serial_clock && !stall_low)
      begin
        serial_clock <= 1'b1;
        rx_strobe <= 1'b1;
        rx_bit <= serial_out;
      end
      else if (phase == 4'(HALF - 1) && serial_clock && !stall_high)
        serial_clock <= 1'b0;
    end
  end
endmodule : serial_controller
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the two-wire framer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic rst;
  logic sel;
  logic [4:0] pins; // ratio high, ratio low, boost, gain high, gain low
  logic [23:0] ch0;
  logic [23:0] ch1;
  logic st_h;
  logic st_l;
  logic sck;
  logic sdo;
  logic mode;
  framer_pkg::strap_t straps;
  logic [11:0] ratio;
  logic [5:0] gain;
  logic boost;
  logic run;
  logic tick;
  logic fres;
  logic rx_stb;
  logic rx_bit;
  int failures;
  int samples_checked;
  int cycles;
  two_wire_framer #(.SETTLE(0)) i_two_wire_framer (.clk(clk), .rst(rst), .serial_clock(sck),
    .interface_select_pin(sel), .ratio_strap_low(pins[3]), .ratio_strap_high(pins[4]),
    .boost_strap(pins[2]), .gain_strap_low(pins[0]), .gain_strap_high(pins[1]),
    .channel0_sample(ch0), .channel1_sample(ch1), .serial_out(sdo), .two_wire_mode(mode),
    .straps(straps), .oversampling_ratio(ratio), .channel0_gain(gain), .boost_full(boost),
    .conversion_run(run), .result_tick(tick), .full_reset(fres));
  serial_controller i_serial_controller (.clk(clk), .rst(rst), .stall_high(st_h),
    .stall_low(st_l), .serial_out(sdo), .serial_clock(sck), .rx_strobe(rx_stb), .rx_bit(rx_bit));
  // free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_val
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // shift in bits taken at serial clock rises
  task automatic get_bits(input int n, inout logic [79:0] v);
    repeat (n)
    begin
      @(posedge clk);
      while (rx_stb !== 1'b1)
        @(posedge clk);
      v = {v[78:0], rx_bit};
    end
  endtask : get_bits
  // reference crc over the data part of a received frame, msb first
  function automatic logic [15:0] crc_of(input logic [79:0] v, input int len);
    logic [15:0] c;
    c = framer_pkg::CRC_SEED;
    for (int i = len - 1; i >= 16; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? framer_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_of
  task automatic latch_pins(input logic [4:0] p);
    @(posedge clk);
    sel <= 1'b0;
    pins <= p;
    repeat (3) @(posedge clk);
    sel <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : latch_pins
  task automatic t_straps;
    logic [11:0] rtab [4] = '{12'h040, 12'h080, 12'h100, 12'h200};
    logic [5:0] gtab [4] = '{6'h01, 6'h08, 6'h10, 6'h20};
    for (int c = 3; c >= 0; c--)
    begin
      latch_pins({2'(c), c[0], 2'(3 - c)});
      check_val(straps, pins, "straps");
      check_val(ratio, rtab[c], "ratio");
      check_val(gain, gtab[3 - c], "gain");
      check_val(boost, c[0], "boost");
    end
    $display("done: straps");
  endtask : t_straps
  task automatic t_low_stall;
    @(posedge clk);
    st_l <= 1'b1;
    repeat (2000) @(posedge clk);
    check_val(fres, 1'b0, "reset on low clock");
    st_l <= 1'b0;
    $display("done: low stall");
  endtask : t_low_stall
  // long high clock; expect reset, then mode from select and start delay
  task automatic watch_reset(input logic to_sel, input int rises);
    int n;
    @(posedge clk);
    // start the hold from a low clock so the timeout is counted from a fresh rise
    while (sck !== 1'b0)
      @(posedge clk);
    sel <= to_sel;
    st_h <= 1'b1;
    n = 0;
    while (fres !== 1'b1 && n < 600)
    begin
      @(posedge clk);
      n++;
    end
    check_val(24'(n >= 448 && n < 480), 24'h000001, "watchdog delay");
    st_h <= 1'b0;
    while (fres !== 1'b0)
      @(posedge clk);
    n = 0;
    while (to_sel && run !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n += int'(rx_stb);
    end
    check_val(mode, to_sel, "mode");
    if (to_sel)
    begin
      check_val(straps, pins, "straps kept");
      check_val(24'(n), 24'(rises), "start delay");
    end
    n = 0;
    repeat (2000)
    begin
      @(posedge clk);
      n += int'(!to_sel && sdo !== 1'b0);
    end
    check_val(24'(n), 24'h000000, "spi mode output");
    $display("done: watchdog reset");
  endtask : watch_reset
  task automatic t_frames(input int len);
    logic [79:0] v;
    int n;
    v = 80'h0;
    n = 0;
    while (tick !== 1'b1)
      @(posedge clk);
    while (v[7:0] !== 8'hA5 && n < 24)
    begin
      get_bits(1, v);
      n++;
    end
    get_bits(len - 16, v);
    for (int f = 0; f < 4; f++)
    begin
      if (f > 0)
        get_bits(len, v);
      check_val(v[len - 1 -: 16], {2'(f), pins, 1'b0, 8'hA5}, "sync");
      if (len == 80)
      begin
        check_val(v[63:40], ch0, "ch0 sample");
        check_val(v[39:16], ch1, "ch1 sample");
      end
      else
      begin
        check_val({8'h00, v[47:32]}, {8'h00, ch0[23:8]}, "ch0 short");
        check_val({8'h00, v[31:16]}, {8'h00, ch1[23:8]}, "ch1 short");
      end
      check_val(v[15:0], crc_of(v, len), "crc");
    end
    v = 80'h0;
    get_bits(len == 80 ? 80 : 16, v);
    if (len == 80)
      check_val(24'(v != 80'h0), 24'h000000, "idle after frames");
    else
      check_val(v[15:0], {2'b00, pins, 1'b0, 8'hA5}, "back to back");
    $display("done: frames");
  endtask : t_frames
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      failures++;
      $display("mismatch at %0t: timeout", $time);
      report_and_stop();
    end
  end
  initial
  begin
    rst = 1'b1;
    sel = 1'b1;
    pins = 5'h0E;
    ch0 = 24'hC3A55A;
    ch1 = 24'h5AF00F;
    st_h = 1'b0;
    st_l = 1'b0;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_straps();
    t_low_stall();
    watch_reset(1'b1, 128);
    t_frames(64);
    latch_pins(5'h0E);
    watch_reset(1'b1, 256);
    t_frames(80);
    watch_reset(1'b0, 0);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire

// *** two_wire_framer.sv ***
// two-wire mode output framer: straps, conversion schedule, frames, watchdog
//
// How it works
// RULE1: interface mode is caught as each reset is left, select pin high means two-wire.
// RULE2: only channel 0 gain, ratio and boost differ from defaults in two-wire mode.
// RULE3: five straps are caught on the select pin's rising edge.
// RULE4: ratio straps 00,01,10,11 give 64,128,256,512.
// RULE5: boost strap low gives half bias current, high gives full.
// RULE6: gain straps 00,01,10,11 give channel 0 gain 1,8,16,32.
// RULE7: controller keeps the serial clock steady and at most 10 MHz.
// RULE8: at ratio 64 a frame is sync, two 16-bit samples, 16-bit crc.
// RULE9: at higher ratios a frame is 80 bits: sync, two 24-bit samples, crc.
// RULE10: sync word carries the five straps and the two frame counter bits.
// RULE11: one sync byte is always 0xA5.
// RULE12: each result goes out as four frames numbered 0 to 3.
// RULE13: pin rests low after the fourth frame; at ratio 64 frames run back to back.
// RULE14: no frames until the filter has settled on its first valid result.
// RULE15: no channel delay; conversions start after 2 x ratio serial clocks.
// RULE16: hard reset is unused in two-wire mode; its pin is a ratio strap.
// RULE17: clock held high past the timeout forces a full reset.
// RULE18: falling edge clears the watchdog; a low clock never resets.
// RULE19: controller keeps the clock above about 138.9 kHz.
// RULE20: to leave, controller drops select, holds clock high until reset completes.
// RULE21: output pin is always driven and low when idle.
// RULE22: old reset, input, select, oscillator, ready pins become the five straps.
// RULE23: bits go msb first, one per clock; crc spans sync and both samples.
// RULE24: both samples of a frame come from one snapshot.
`timescale 1ns/1ps
`default_nettype none
module two_wire_framer #(
  parameter int SETTLE = framer_pkg::SETTLE_RESULTS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic interface_select_pin,
  input wire logic ratio_strap_low,
  input wire logic ratio_strap_high,
  input wire logic boost_strap,
  input wire logic gain_strap_low,
  input wire logic gain_strap_high,
  input wire logic [23:0] channel0_sample,
  input wire logic [23:0] channel1_sample,
  output logic serial_out,
  output logic two_wire_mode,
  output framer_pkg::strap_t straps,
  output logic [11:0] oversampling_ratio,
  output logic [5:0] channel0_gain,
  output logic boost_full,
  output logic conversion_run,
  output logic result_tick,
  output logic full_reset
);

  logic sck_q;
  logic sck_rise;
  logic sck_fall;
  logic in_reset;
  logic select_q;
  logic hard_reset;
  logic wd_fire;
  framer_pkg::sched_t sched;
  logic [11:0] sched_count;
  logic [1:0] settled;
  logic frames_pending;
  logic frame_active;
  logic [6:0] bit_index;
  logic [1:0] frame_count;
  logic [63:0] shift_data;
  logic [23:0] snap0;
  logic [23:0] snap1;
  logic short_frame;
  logic [6:0] data_bits;
  logic [6:0] frame_bits;
  logic [63:0] load_word;
  logic crc_clear;
  logic crc_feed;
  logic crc_bit;
  logic crc_shift;
  logic [15:0] crc_value;

  // ratio strap code to oversampling ratio
  function automatic logic [11:0] ratio_of(input logic [1:0] code);
    case (code)
      2'b00: ratio_of = framer_pkg::RATIO_00; // RULE4
      2'b01: ratio_of = framer_pkg::RATIO_01;
      2'b10: ratio_of = framer_pkg::RATIO_10;
      default: ratio_of = framer_pkg::RATIO_11;
    endcase
  endfunction : ratio_of

  // gain strap code to channel 0 gain
  function automatic logic [5:0] gain_of(input logic [1:0] code);
    case (code)
      2'b00: gain_of = framer_pkg::GAIN_00; // RULE6
      2'b01: gain_of = framer_pkg::GAIN_01;
      2'b10: gain_of = framer_pkg::GAIN_10;
      default: gain_of = framer_pkg::GAIN_11;
    endcase
  endfunction : gain_of

  // left-aligned data part of a frame for a given frame number
  function automatic logic [63:0] frame_word(input framer_pkg::strap_t s,
                                            input logic [1:0] count,
                                            input logic [23:0] c0,
                                            input logic [23:0] c1,
                                            input logic short_f);
    logic [15:0] sync;
    sync = {count, s.ratio_strap_high, s.ratio_strap_low, s.boost,
            s.gain_strap_high, s.gain_strap_low, 1'b0, framer_pkg::SYNC_PATTERN}; // RULE10 RULE11
    if (short_f)
      frame_word = {sync, c0[23:8], c1[23:8], 16'h0000}; // RULE8
    else
      frame_word = {sync, c0, c1}; // RULE9
  endfunction : frame_word

  // serial clock is synchronous to clk; edges found against last sample
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sck_q <= 1'b0;
    else
      sck_q <= serial_clock;
  end
  assign sck_rise = serial_clock & ~sck_q;
  assign sck_fall = ~serial_clock & sck_q;

  clock_watchdog u_watchdog (
    .clk(clk),
    .rst(rst),
    .sck_level(serial_clock),
    .sck_rise(sck_rise & two_wire_mode & ~in_reset),
    .fire(wd_fire)
  );

  // the strap pin doubles as active-low hard reset only outside two-wire mode
  assign hard_reset = ~two_wire_mode & ~ratio_strap_low & ~in_reset; // RULE16 RULE22
  assign full_reset = in_reset;

  // reset state: entered by power-on, hard reset or watchdog; mode caught on exit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      in_reset <= 1'b1;
      two_wire_mode <= 1'b0;
    end
    else if (wd_fire || hard_reset)
      in_reset <= 1'b1; // RULE17
    else if (in_reset)
    begin
      in_reset <= 1'b0;
      two_wire_mode <= interface_select_pin; // RULE1
    end
  end

  // straps follow a rising select edge, or a select already high at reset exit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      select_q <= 1'b0;
      straps <= '0;
    end
    else
    begin
      select_q <= interface_select_pin;
      if (interface_select_pin && (!select_q || in_reset))
        straps <= '{ratio_strap_high, ratio_strap_low, boost_strap,
                    gain_strap_high, gain_strap_low}; // RULE3 RULE22
    end
  end

  // only these three settings leave their defaults
  assign oversampling_ratio = ratio_of({straps.ratio_strap_high, straps.ratio_strap_low}); // RULE2
  assign channel0_gain = gain_of({straps.gain_strap_high, straps.gain_strap_low}); // RULE2
  assign boost_full = straps.boost; // RULE5
  assign short_frame = (oversampling_ratio == framer_pkg::RATIO_00);
  assign data_bits = short_frame ? 7'(framer_pkg::SHORT_DATA_BITS) : 7'(framer_pkg::LONG_DATA_BITS);
  assign frame_bits = 7'(data_bits + 7'(framer_pkg::CRC_BITS));
  assign conversion_run = (sched == framer_pkg::SCHED_CONVERT);

  // conversion schedule counted in serial clock periods: start delay, then results
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sched <= framer_pkg::SCHED_OFF;
      sched_count <= 12'h000;
      settled <= 2'h0;
      result_tick <= 1'b0;
    end
    else if (in_reset || !two_wire_mode)
    begin
      sched <= framer_pkg::SCHED_OFF;
      sched_count <= 12'h000;
      settled <= 2'h0;
      result_tick <= 1'b0;
    end
    else
    begin
      result_tick <= 1'b0;
      if (sck_rise)
      begin
        case (sched)
          framer_pkg::SCHED_OFF:
          begin
            sched <= framer_pkg::SCHED_START;
            sched_count <= 12'h001;
          end
          framer_pkg::SCHED_START:
          begin
            // both channels start together; no phase offset exists here
            if (sched_count == 12'({oversampling_ratio, 1'b0}) - 12'h001) // RULE15
            begin
              sched <= framer_pkg::SCHED_CONVERT;
              sched_count <= 12'h000;
            end
            else
              sched_count <= sched_count + 12'h001;
          end
          framer_pkg::SCHED_CONVERT:
          begin
            // one result every four ratio periods of the serial clock
            if (sched_count == 12'({oversampling_ratio, 2'b00}) - 12'h001)
            begin
              sched_count <= 12'h000;
              if (32'(settled) >= SETTLE)
                result_tick <= 1'b1; // RULE14
              else
                settled <= settled + 2'h1;
            end
            else
              sched_count <= sched_count + 12'h001;
          end
          default: sched <= framer_pkg::SCHED_OFF;
        endcase
      end
    end
  end

  // snapshot both channels on the same tick so frames never mix conversions
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      snap0 <= 24'h000000;
      snap1 <= 24'h000000;
    end
    else if (result_tick)
    begin
      snap0 <= channel0_sample; // RULE24
      snap1 <= channel1_sample; // RULE24
    end
  end

  // a tick arriving in the same cycle as a load keeps the request alive
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      frames_pending <= 1'b0;
    else if (in_reset)
      frames_pending <= 1'b0;
    else if (result_tick)
      frames_pending <= 1'b1;
    else if (sck_fall)
      frames_pending <= 1'b0;
  end

  assign load_word = frame_word(straps, frames_pending ? 2'h0 : frame_count + 2'h1, snap0, snap1,
                                short_frame); // RULE12

  // shifter: bits change on falling clock edges so the receiver samples on rising
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      serial_out <= 1'b0;
      frame_active <= 1'b0;
      bit_index <= 7'h00;
      frame_count <= 2'h0;
      shift_data <= 64'h0000000000000000;
    end
    else if (in_reset || !two_wire_mode)
    begin
      serial_out <= 1'b0; // RULE21
      frame_active <= 1'b0;
      bit_index <= 7'h00;
      frame_count <= 2'h0;
    end
    else if (sck_fall)
    begin
      if (frames_pending)
      begin
        // at ratio 64 this lands on the fall right after the previous last bit
        shift_data <= {load_word[62:0], 1'b0}; // RULE13
        serial_out <= load_word[63]; // RULE23
        frame_count <= 2'h0; // RULE12
        bit_index <= 7'h01;
        frame_active <= 1'b1;
      end
      else if (frame_active)
      begin
        if (bit_index == frame_bits)
        begin
          if (frame_count == 2'(framer_pkg::FRAMES_PER_RESULT - 1))
          begin
            frame_active <= 1'b0;
            serial_out <= 1'b0; // RULE13
          end
          else
          begin
            frame_count <= frame_count + 2'h1; // RULE12
            shift_data <= {load_word[62:0], 1'b0};
            serial_out <= load_word[63];
            bit_index <= 7'h01;
          end
        end
        else if (bit_index < data_bits)
        begin
          serial_out <= shift_data[63]; // RULE23
          shift_data <= {shift_data[62:0], 1'b0};
          bit_index <= bit_index + 7'h01;
        end
        else
        begin
          serial_out <= crc_value[15]; // RULE23
          bit_index <= bit_index + 7'h01;
        end
      end
      else
        serial_out <= 1'b0; // RULE21
    end
  end

  // crc folds every data bit as it leaves, then empties itself onto the pin
  always_comb
  begin
    crc_clear = 1'b0;
    crc_feed = 1'b0;
    crc_bit = 1'b0;
    crc_shift = 1'b0;
    if (sck_fall && two_wire_mode && !in_reset)
    begin
      if (frames_pending || (frame_active && bit_index == frame_bits &&
          frame_count != 2'(framer_pkg::FRAMES_PER_RESULT - 1)))
      begin
        crc_clear = 1'b1;
        crc_feed = 1'b1;
        crc_bit = load_word[63];
      end
      else if (frame_active && bit_index < data_bits)
      begin
        crc_feed = 1'b1; // RULE23
        crc_bit = shift_data[63];
      end
      else if (frame_active && bit_index < frame_bits)
        crc_shift = 1'b1;
    end
  end

  frame_crc u_crc (
    .clk(clk),
    .rst(rst),
    .clear(crc_clear),
    .feed(crc_feed),
    .bit_in(crc_bit),
    .shift(crc_shift),
    .crc(crc_value)
  );

endmodule : two_wire_framer
`default_nettype wire

// *** two_wire_framer_checker.sv ***
// port assertions for the two-wire framer
`timescale 1ns/1ps
`default_nettype none
module two_wire_framer_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic interface_select_pin,
  input wire logic ratio_strap_low,
  input wire logic ratio_strap_high,
  input wire logic boost_strap,
  input wire logic gain_strap_low,
  input wire logic gain_strap_high,
  input wire logic serial_out,
  input wire logic two_wire_mode,
  input wire framer_pkg::strap_t straps,
  input wire logic [11:0] oversampling_ratio,
  input wire logic [5:0] channel0_gain,
  input wire logic boost_full,
  input wire logic result_tick,
  input wire logic full_reset
);
  logic [9:0] high_run;
  logic sent;
  logic fired;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // length of the current high phase, saturating so it never wraps
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      high_run <= 10'h000;
    else if (!serial_clock)
      high_run <= 10'h000;
    else if (high_run != 10'h3FF)
      high_run <= high_run + 10'h001;
  end
  // set once a settled result has been announced
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sent <= 1'b0;
    else if (full_reset)
      sent <= 1'b0;
    else if (result_tick)
      sent <= 1'b1;
  end
  // reset seen within the current high phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fired <= 1'b0;
    else if (!serial_clock)
      fired <= 1'b0;
    else if (full_reset)
      fired <= 1'b1;
  end
  a_ratio_decode: assert property (oversampling_ratio == (12'h040 << straps[4:3]))
    else $error("ratio does not follow straps");
  a_gain_decode: assert property (channel0_gain == ((straps[1:0] == 2'b00) ? 6'h01
    : (6'h04 << straps[1:0]))) else $error("gain does not follow straps");
  a_boost_follow: assert property (boost_full == straps.boost)
    else $error("boost does not follow strap");
  a_mode_latch: assert property ($fell(full_reset) |-> two_wire_mode == $past(interface_select_pin))
    else $error("mode not taken at reset exit");
  a_strap_catch: assert property ($rose(interface_select_pin) && two_wire_mode && !full_reset
    |-> ##[1:3] straps == {ratio_strap_high, ratio_strap_low, boost_strap, gain_strap_high,
    gain_strap_low}) else $error("straps not caught on select rise");
  a_idle_reset: assert property (full_reset |=> !serial_out)
    else $error("output high during reset");
  a_no_early: assert property (!sent |-> !serial_out)
    else $error("output before first result");
  a_watch_fire: assert property (high_run == 10'h1E0 |-> fired)
    else $error("no reset on long high clock");
  a_watch_quiet: assert property ($rose(full_reset) |-> $past(high_run) >= 10'h1C0)
    else $error("reset without long high clock");
endmodule : two_wire_framer_checker
bind two_wire_framer two_wire_framer_checker i_chk (.clk(clk), .rst(rst),
  .serial_clock(serial_clock), .interface_select_pin(interface_select_pin),
  .ratio_strap_low(ratio_strap_low), .ratio_strap_high(ratio_strap_high),
  .boost_strap(boost_strap), .gain_strap_low(gain_strap_low),
  .gain_strap_high(gain_strap_high), .serial_out(serial_out), .two_wire_mode(two_wire_mode),
  .straps(straps), .oversampling_ratio(oversampling_ratio), .channel0_gain(channel0_gain),
  .boost_full(boost_full), .result_tick(result_tick), .full_reset(full_reset));
`default_nettype wire
